// >>> include/cpx_pkg.sv
package cpx_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] FLAGS_OFS = 8'h01;
	localparam logic [7:0] PC_LO_OFS = 8'h02;
	localparam logic [7:0] PC_HI_OFS = 8'h03;
	localparam logic [7:0] SP_LO_OFS = 8'h04;
	localparam logic [7:0] SP_HI_OFS = 8'h05;
	localparam logic [2:0] GPR_PAGE = 3'h1;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h01;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] SP_RESET = 16'h0FFF;
	localparam logic [7:0] GPR_RESET = 8'h00;
	// ------------------------------------------------------------
	// Status flag positions
	// ------------------------------------------------------------
	localparam int F_C = 0;
	localparam int F_Z = 1;
	localparam int F_N = 2;
	localparam int F_V = 3;
	localparam int F_S = 4;
	localparam int F_H = 5;
	localparam int F_T = 6;
	localparam int F_I = 7;
	// ------------------------------------------------------------
	// Pointers, address modes, memory map
	// ------------------------------------------------------------
	localparam logic [1:0] PTR_X = 2'h0;
	localparam logic [1:0] PTR_Y = 2'h1;
	localparam logic [1:0] PTR_Z = 2'h2;
	localparam logic [4:0] X_LO = 5'h1A;
	localparam logic [4:0] Y_LO = 5'h1C;
	localparam logic [4:0] Z_LO = 5'h1E;
	localparam logic [1:0] AM_PLAIN = 2'h0;
	localparam logic [1:0] AM_POSTINC = 2'h1;
	localparam logic [1:0] AM_PREDEC = 2'h2;
	localparam logic [15:0] NVM_BASE = 16'h1000;
	localparam int DISP_W = 6;
	localparam int BR_W = 7;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_BR_VS = 5'h00, OP_BR_VC = 5'h01, OP_BR_IE = 5'h02,
		OP_BR_ID = 5'h03, OP_COPY = 5'h04, OP_COPY_PAIR = 5'h05,
		OP_LOAD_IMM = 5'h06, OP_LOAD_DIRECT = 5'h07,
		OP_STORE_DIRECT = 5'h08, OP_LOAD_IND = 5'h09,
		OP_STORE_IND = 5'h0A, OP_LOAD_DISP = 5'h0B,
		OP_STORE_DISP = 5'h0C, OP_PGM_LOAD = 5'h0D, OP_IO_IN = 5'h0E,
		OP_IO_OUT = 5'h0F, OP_PUSH = 5'h10, OP_POP = 5'h11,
		OP_SHL = 5'h12, OP_ROL = 5'h13, OP_SHR = 5'h14, OP_ROR = 5'h15,
		OP_ASR = 5'h16, OP_IO_SET = 5'h17, OP_IO_CLR = 5'h18,
		OP_BIT_TO_T = 5'h19, OP_T_TO_BIT = 5'h1A, OP_FLAG_SET = 5'h1B,
		OP_FLAG_CLR = 5'h1C
	} cpx_op_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_EXTRA = 3'b001, ST_MEM = 3'b010,
		ST_BRANCH = 3'b011, ST_PGM_RD = 3'b100, ST_PGM_WB = 3'b101
	} cpx_state_e;
	typedef struct packed {
		cpx_op_e op;
		logic [4:0] rd;
		logic [4:0] rr;
		logic [1:0] ptr;
		logic [1:0] amode;
		logic [2:0] bitn;
		logic [15:0] k;
	} cpx_instr_s;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} cpx_dmem_s;
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} cpx_io_s;
endpackage : cpx_pkg

// >>> rtl/cpx_exec.sv
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module cpx_exec (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic instr_valid,
	input wire cpx_pkg::cpx_instr_s instr,
	output logic instr_ready,
	output logic [15:0] pc,
	output logic [7:0] flags,
	output cpx_pkg::cpx_dmem_s dmem_out,
	input wire logic [7:0] dmem_rdata,
	input wire logic dmem_wait,
	output logic [15:0] pmem_addr,
	output logic pmem_re,
	input wire logic [15:0] pmem_rdata,
	output cpx_pkg::cpx_io_s io_out,
	input wire logic [7:0] io_rdata,
	input wire logic [7:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [7:0] sw_rdata
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	cpx_pkg::cpx_state_e state, next_state;
	logic [7:0] rf [32];
	logic [15:0] sp;
	logic run;
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata;
	logic mem_we, mem_re, mem_first;
	logic [4:0] late_idx;
	logic pgm_hi;
	logic [7:0] pgm_byte;
	logic [7:0] next_flags;
	logic [7:0] next_sw_rdata;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	cpx_pkg::cpx_op_e op;
	wire accept;
	wire is_branch, is_direct, is_load, is_store, is_pgm, is_shift;
	wire is_ind, is_disp, is_io_bit;
	assign op = instr.op;
	assign accept = instr_valid & instr_ready;
	assign is_branch = op == cpx_pkg::OP_BR_VS || op == cpx_pkg::OP_BR_VC
		|| op == cpx_pkg::OP_BR_IE || op == cpx_pkg::OP_BR_ID;
	assign is_direct = op == cpx_pkg::OP_LOAD_DIRECT
		|| op == cpx_pkg::OP_STORE_DIRECT;
	assign is_ind = op == cpx_pkg::OP_LOAD_IND
		|| op == cpx_pkg::OP_STORE_IND;
	assign is_disp = op == cpx_pkg::OP_LOAD_DISP
		|| op == cpx_pkg::OP_STORE_DISP;
	assign is_load = op == cpx_pkg::OP_LOAD_DIRECT
		|| op == cpx_pkg::OP_LOAD_IND || op == cpx_pkg::OP_LOAD_DISP
		|| op == cpx_pkg::OP_POP;
	assign is_store = op == cpx_pkg::OP_STORE_DIRECT
		|| op == cpx_pkg::OP_STORE_IND || op == cpx_pkg::OP_STORE_DISP
		|| op == cpx_pkg::OP_PUSH;
	assign is_pgm = op == cpx_pkg::OP_PGM_LOAD;
	assign is_shift = op == cpx_pkg::OP_SHL || op == cpx_pkg::OP_ROL
		|| op == cpx_pkg::OP_SHR || op == cpx_pkg::OP_ROR
		|| op == cpx_pkg::OP_ASR;
	assign is_io_bit = op == cpx_pkg::OP_IO_SET
		|| op == cpx_pkg::OP_IO_CLR;

	// ------------------------------------------------------------
	// Operands and pointers
	// ------------------------------------------------------------
	wire [7:0] rd_val, rr_val, bmask;
	wire [1:0] eff_ptr;
	wire [4:0] ptr_lo;
	wire [15:0] ptr_val, ptr_inc, ptr_dec, disp, ea;
	assign rd_val = rf[instr.rd];
	assign rr_val = rf[instr.rr];
	assign bmask = 8'h01 << instr.bitn;
	assign eff_ptr = is_pgm ? cpx_pkg::PTR_Z : instr.ptr;
	assign ptr_lo = eff_ptr == cpx_pkg::PTR_X ? cpx_pkg::X_LO
		: eff_ptr == cpx_pkg::PTR_Y ? cpx_pkg::Y_LO : cpx_pkg::Z_LO;
	assign ptr_val = {rf[ptr_lo | 5'h01], rf[ptr_lo]};
	assign ptr_inc = ptr_val + 16'h0001;
	assign ptr_dec = ptr_val - 16'h0001;
	assign disp = {{(16 - cpx_pkg::DISP_W){1'b0}},
		instr.k[cpx_pkg::DISP_W-1:0]};
	assign ea = is_direct ? instr.k
		: is_disp ? ptr_val + disp
		: op == cpx_pkg::OP_PUSH ? sp
		: op == cpx_pkg::OP_POP ? sp + 16'h0001
		: instr.amode == cpx_pkg::AM_PREDEC ? ptr_dec
		: ptr_val;

	// ------------------------------------------------------------
	// Branch unit
	// ------------------------------------------------------------
	wire br_cond, br_taken;
	wire [15:0] br_disp, br_target, next_pc;
	assign br_cond = op == cpx_pkg::OP_BR_VS ? flags[cpx_pkg::F_V]
		: op == cpx_pkg::OP_BR_VC ? !flags[cpx_pkg::F_V]
		: op == cpx_pkg::OP_BR_IE ? flags[cpx_pkg::F_I]
		: !flags[cpx_pkg::F_I];
	assign br_taken = is_branch & br_cond;
	assign br_disp = {{(17 - cpx_pkg::BR_W){instr.k[cpx_pkg::BR_W-1]}},
		instr.k[cpx_pkg::BR_W-2:0]};
	assign br_target = pc + br_disp + 16'h0001;
	assign next_pc = br_taken ? br_target
		: is_direct ? pc + 16'h0002 : pc + 16'h0001;

	// ------------------------------------------------------------
	// Shift unit
	// ------------------------------------------------------------
	wire [7:0] sh_res;
	wire sh_c, sh_left;
	assign sh_left = op == cpx_pkg::OP_SHL || op == cpx_pkg::OP_ROL;
	assign sh_res = op == cpx_pkg::OP_SHL ? {rd_val[6:0], 1'b0}
		: op == cpx_pkg::OP_ROL ? {rd_val[6:0], flags[cpx_pkg::F_C]}
		: op == cpx_pkg::OP_SHR ? {1'b0, rd_val[7:1]}
		: op == cpx_pkg::OP_ROR ? {flags[cpx_pkg::F_C], rd_val[7:1]}
		: {rd_val[7], rd_val[7:1]};
	assign sh_c = sh_left ? rd_val[7] : rd_val[0];

	// ------------------------------------------------------------
	// Memory sequencing
	// ------------------------------------------------------------
	wire nvm_hit, mem_done;
	assign nvm_hit = mem_addr >= cpx_pkg::NVM_BASE;
	assign mem_done = state == cpx_pkg::ST_MEM && !dmem_wait
		&& !(nvm_hit && mem_first);
	assign instr_ready = run && (state == cpx_pkg::ST_IDLE
		|| (state == cpx_pkg::ST_MEM && mem_we && mem_done));
	assign dmem_out.addr = mem_addr;
	assign dmem_out.wdata = mem_wdata;
	assign dmem_out.we = mem_we && state == cpx_pkg::ST_MEM;
	assign dmem_out.re = mem_re && state == cpx_pkg::ST_MEM;
	assign pmem_re = state == cpx_pkg::ST_PGM_RD;

	always_comb begin
		next_state = state;
		if (accept) begin
			if (br_taken)
				next_state = cpx_pkg::ST_BRANCH;
			else if (is_direct)
				next_state = cpx_pkg::ST_EXTRA;
			else if (is_load || is_store)
				next_state = cpx_pkg::ST_MEM;
			else if (is_pgm)
				next_state = cpx_pkg::ST_PGM_RD;
			else
				next_state = cpx_pkg::ST_IDLE;
		end else begin
			case (state)
				cpx_pkg::ST_EXTRA: next_state = cpx_pkg::ST_MEM;
				cpx_pkg::ST_MEM: next_state = mem_done ? cpx_pkg::ST_IDLE
					: cpx_pkg::ST_MEM;
				cpx_pkg::ST_PGM_RD: next_state = cpx_pkg::ST_PGM_WB;
				default: next_state = cpx_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= cpx_pkg::ST_IDLE;
			pc <= cpx_pkg::PC_RESET;
			sp <= cpx_pkg::SP_RESET;
			flags <= cpx_pkg::FLAGS_RESET;
		end else begin
			state <= next_state;
			flags <= next_flags;
			if (accept)
				pc <= next_pc;
			if (accept && op == cpx_pkg::OP_PUSH)
				sp <= sp - 16'h0001;
			else if (accept && op == cpx_pkg::OP_POP)
				sp <= sp + 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			mem_we <= 1'b0;
			mem_re <= 1'b0;
			mem_first <= 1'b0;
			late_idx <= 5'h00;
		end else if (accept && (is_load || is_store)) begin
			mem_addr <= ea;
			mem_wdata <= rr_val;
			mem_we <= is_store;
			mem_re <= is_load;
			mem_first <= 1'b1;
			late_idx <= instr.rd;
		end else if (accept && is_pgm) begin
			late_idx <= instr.rd;
		end else if (state == cpx_pkg::ST_MEM) begin
			mem_first <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pmem_addr <= 16'h0000;
			pgm_hi <= 1'b0;
			pgm_byte <= 8'h00;
		end else if (accept && is_pgm) begin
			pmem_addr <= {1'b0, ptr_val[15:1]};
			pgm_hi <= ptr_val[0];
		end else if (state == cpx_pkg::ST_PGM_RD) begin
			pgm_byte <= pgm_hi ? pmem_rdata[15:8] : pmem_rdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// I/O space
	// ------------------------------------------------------------
	assign io_out.addr = is_io_bit ? {1'b0, instr.k[4:0]} : instr.k[5:0];
	assign io_out.re = accept && (op == cpx_pkg::OP_IO_IN || is_io_bit);
	assign io_out.we = accept && (op == cpx_pkg::OP_IO_OUT || is_io_bit);
	assign io_out.wdata = op == cpx_pkg::OP_IO_OUT ? rr_val
		: op == cpx_pkg::OP_IO_SET ? io_rdata | bmask
		: io_rdata & ~bmask;

	// ------------------------------------------------------------
	// Register file write ports
	// ------------------------------------------------------------
	wire ex_we, pair_we, late_we, ptr_upd;
	wire [7:0] ex_data, late_data;
	wire [4:0] pair_idx;
	wire [15:0] pair_data;
	assign ex_we = accept && (op == cpx_pkg::OP_COPY
		|| op == cpx_pkg::OP_LOAD_IMM || op == cpx_pkg::OP_IO_IN
		|| is_shift || op == cpx_pkg::OP_T_TO_BIT);
	assign ex_data = op == cpx_pkg::OP_COPY ? rr_val
		: op == cpx_pkg::OP_LOAD_IMM ? instr.k[7:0]
		: op == cpx_pkg::OP_IO_IN ? io_rdata
		: is_shift ? sh_res
		: flags[cpx_pkg::F_T] ? rd_val | bmask : rd_val & ~bmask;
	assign ptr_upd = (is_ind && instr.amode != cpx_pkg::AM_PLAIN)
		|| (is_pgm && instr.amode == cpx_pkg::AM_POSTINC);
	assign pair_we = accept && (op == cpx_pkg::OP_COPY_PAIR || ptr_upd);
	assign pair_idx = op == cpx_pkg::OP_COPY_PAIR ? {instr.rd[4:1], 1'b0}
		: ptr_lo;
	assign pair_data = op == cpx_pkg::OP_COPY_PAIR
		? {rf[{instr.rr[4:1], 1'b1}], rf[{instr.rr[4:1], 1'b0}]}
		: instr.amode == cpx_pkg::AM_PREDEC ? ptr_dec
		: ptr_inc;
	assign late_we = (mem_re && mem_done)
		|| state == cpx_pkg::ST_PGM_WB;
	assign late_data = state == cpx_pkg::ST_PGM_WB ? pgm_byte : dmem_rdata;

	for (genvar i = 0; i < 32; i++) begin : g_rf
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n)
				rf[i] <= cpx_pkg::GPR_RESET;
			else if (late_we && late_idx == 5'(i))
				rf[i] <= late_data;
			else if (pair_we && pair_idx == 5'(i))
				rf[i] <= pair_data[7:0];
			else if (pair_we && (pair_idx | 5'h01) == 5'(i))
				rf[i] <= pair_data[15:8];
			else if (ex_we && instr.rd == 5'(i))
				rf[i] <= ex_data;
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	always_comb begin
		next_flags = flags;
		if (accept && is_shift) begin
			next_flags[cpx_pkg::F_C] = sh_c;
			next_flags[cpx_pkg::F_Z] = sh_res == 8'h00;
			next_flags[cpx_pkg::F_N] = sh_res[7];
			next_flags[cpx_pkg::F_V] = sh_res[7] ^ sh_c;
			if (sh_left)
				next_flags[cpx_pkg::F_H] = rd_val[3];
		end else if (accept && op == cpx_pkg::OP_BIT_TO_T) begin
			next_flags[cpx_pkg::F_T] = rr_val[instr.bitn];
		end else if (accept && op == cpx_pkg::OP_FLAG_SET) begin
			next_flags[instr.bitn] = 1'b1;
		end else if (accept && op == cpx_pkg::OP_FLAG_CLR) begin
			next_flags[instr.bitn] = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Software register port
	// ------------------------------------------------------------
	always_comb begin
		next_sw_rdata = 8'h00;
		if (!sw_rd)
			next_sw_rdata = 8'h00;
		else if (sw_addr == cpx_pkg::CTRL_OFS)
			next_sw_rdata = {7'h00, run};
		else if (sw_addr == cpx_pkg::FLAGS_OFS)
			next_sw_rdata = flags;
		else if (sw_addr == cpx_pkg::PC_LO_OFS)
			next_sw_rdata = pc[7:0];
		else if (sw_addr == cpx_pkg::PC_HI_OFS)
			next_sw_rdata = pc[15:8];
		else if (sw_addr == cpx_pkg::SP_LO_OFS)
			next_sw_rdata = sp[7:0];
		else if (sw_addr == cpx_pkg::SP_HI_OFS)
			next_sw_rdata = sp[15:8];
		else if (sw_addr[7:5] == cpx_pkg::GPR_PAGE)
			next_sw_rdata = rf[sw_addr[4:0]];
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			run <= cpx_pkg::CTRL_RESET[cpx_pkg::CTRL_RUN_BIT];
			sw_rdata <= 8'h00;
		end else begin
			sw_rdata <= next_sw_rdata;
			if (sw_wr && sw_addr == cpx_pkg::CTRL_OFS)
				run <= sw_wdata[cpx_pkg::CTRL_RUN_BIT];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	sequence seq_bubble;
		state == cpx_pkg::ST_BRANCH && !instr_ready
			##1 state == cpx_pkg::ST_IDLE;
	endsequence
	sequence seq_pgm;
		pmem_re && !instr_ready ##1 state == cpx_pkg::ST_PGM_WB
			&& !instr_ready ##1 state == cpx_pkg::ST_IDLE;
	endsequence

	a_branch_taken: assert property (accept && br_taken |=>
		pc == $past(br_target) and seq_bubble)
		else $error("taken branch target or bubble wrong");
	a_branch_not_taken: assert property (accept && is_branch && !br_taken
		|=> state == cpx_pkg::ST_IDLE && pc == $past(pc) + 16'h0001
		&& flags == $past(flags))
		else $error("untaken branch not single cycle");
	a_branch_back: assert property (accept && br_taken
		&& instr.k[cpx_pkg::BR_W-1] |=> pc <= $past(pc))
		else $error("negative displacement went forward");
	a_direct_load: assert property (accept && op == cpx_pkg::OP_LOAD_DIRECT
		|=> !instr_ready ##1 dmem_out.re
		&& dmem_out.addr == $past(instr.k, 2))
		else $error("direct load timing or address wrong");
	a_direct_store: assert property (accept
		&& op == cpx_pkg::OP_STORE_DIRECT |=> !instr_ready
		##1 dmem_out.we && dmem_out.wdata == $past(rr_val, 2))
		else $error("direct store timing or data wrong");
	a_post_inc: assert property (accept && is_ind
		&& instr.amode == cpx_pkg::AM_POSTINC
		|=> dmem_out.addr == $past(ptr_val))
		else $error("post increment used new pointer");
	a_pre_dec: assert property (accept && is_ind
		&& instr.amode == cpx_pkg::AM_PREDEC
		|=> dmem_out.addr == $past(ptr_val) - 16'h0001)
		else $error("pre decrement address wrong");
	a_disp_addr: assert property (accept && is_disp
		|=> dmem_out.addr == $past(ptr_val) + $past(disp))
		else $error("displacement address wrong");
	a_store_one: assert property (accept && op == cpx_pkg::OP_STORE_IND
		|=> dmem_out.we && (instr_ready || dmem_wait || nvm_hit || !run))
		else $error("indirect store not one cycle");
	a_pgm_three: assert property (accept && is_pgm |=> seq_pgm)
		else $error("program load not three cycles");
	a_nvm_extra: assert property (state == cpx_pkg::ST_MEM && mem_first
		&& nvm_hit |-> !instr_ready ##1 state == cpx_pkg::ST_MEM)
		else $error("nonvolatile access missed extra cycle");
	a_shift_carry: assert property (accept && op == cpx_pkg::OP_SHL
		|=> flags[cpx_pkg::F_C] == $past(rd_val[7])
		&& flags[cpx_pkg::F_V] == (flags[cpx_pkg::F_N] ^ flags[cpx_pkg::F_C]))
		else $error("left shift flags wrong");
	a_flag_force: assert property (accept && op == cpx_pkg::OP_FLAG_SET
		|=> flags[$past(instr.bitn)])
		else $error("flag set did not take");
endmodule : cpx_exec

// >>> sim/cpx_mem_model.sv
`timescale 1ns/1ps
module cpx_mem_model (
	input wire logic mclk,
	input wire logic slow,
	input wire cpx_pkg::cpx_dmem_s dmem_out,
	output logic [7:0] dmem_rdata,
	output logic dmem_wait,
	input wire logic [15:0] pmem_addr,
	input wire logic pmem_re,
	output logic [15:0] pmem_rdata,
	input wire cpx_pkg::cpx_io_s io_out,
	output logic [7:0] io_rdata
);
	// ----------------------------------------
	// Storage and stall counter
	// ----------------------------------------
	logic [7:0] mem [0:255];
	logic [7:0] io [0:63];
	logic [1:0] wcnt;
	wire logic [7:0] d_sel = mem[dmem_out.addr[7:0]];
	wire logic [7:0] i_sel = io[io_out.addr];
	wire logic [15:0] p_pat = {~pmem_addr[7:0], pmem_addr[7:0]};
	wire logic d_acc = dmem_out.re | dmem_out.we;
	initial begin
		wcnt = 2'h0;
		for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
		for (int i = 0; i < 64; i++) io[i] = i[7:0];
	end
	// Released lines show the inverse, not the last value
	assign dmem_rdata = dmem_out.re ? d_sel : ~d_sel;
	assign io_rdata = io_out.re ? i_sel : ~i_sel;
	assign pmem_rdata = pmem_re ? p_pat : ~p_pat;
	// Slow mode stalls an access for two cycles, unless it directly follows another access with no idle cycle between them
	assign dmem_wait = slow && d_acc && wcnt != 2'h2;
	always @(posedge mclk) begin
		wcnt <= d_acc ? (wcnt == 2'h2 ? wcnt : wcnt + 2'h1) : 2'h0;
		if (dmem_out.we && !dmem_wait) mem[dmem_out.addr[7:0]] <= dmem_out.wdata;
		if (io_out.we) io[io_out.addr] <= io_out.wdata;
	end
endmodule : cpx_mem_model

// >>> sim/tb_cpu_transfer_bitop_branch_exec.sv
`timescale 1ns/1ps
module tb_cpu_transfer_bitop_branch_exec;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic mclk, arst_n, vld, sw_wr, sw_rd, slow, instr_ready;
	logic dmem_wait, pmem_re;
	logic [7:0] sw_addr, sw_wdata, sw_rdata, flags, dmem_rdata, io_rdata;
	logic [7:0] rv, m;
	logic [15:0] pc, pmem_addr, pmem_rdata, pa, ob;
	cpx_pkg::cpx_instr_s ins;
	cpx_pkg::cpx_dmem_s dmem_out;
	cpx_pkg::cpx_io_s io_out;
	int n_fail, num_checks, lastc;
	int ticks = 0;
	cpx_exec i_dut (.mclk, .arst_n, .instr_valid(vld), .instr(ins),
		.instr_ready, .pc, .flags, .dmem_out, .dmem_rdata, .dmem_wait,
		.pmem_addr, .pmem_re, .pmem_rdata, .io_out, .io_rdata, .sw_addr,
		.sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
	cpx_mem_model i_mem (.mclk, .slow, .dmem_out, .dmem_rdata, .dmem_wait,
		.pmem_addr, .pmem_re, .pmem_rdata, .io_out, .io_rdata);
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic summarize;
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge mclk);
		sw_rd <= 1'b0;
		#1 chk(sw_rdata, e);
	endtask : rc
	task automatic rpc;
		@(posedge mclk);
		sw_addr <= cpx_pkg::PC_LO_OFS;
		sw_rd <= 1'b1;
		@(posedge mclk);
		sw_addr <= cpx_pkg::PC_HI_OFS;
		#1 pa[7:0] = sw_rdata;
		@(posedge mclk);
		sw_rd <= 1'b0;
		#1 pa[15:8] = sw_rdata;
	endtask : rpc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge mclk);
		sw_wr <= 1'b0;
	endtask : wr
	task automatic ex(input cpx_pkg::cpx_op_e op, input logic [4:0] d, r,
		input logic [3:0] pm, input logic [2:0] b, input logic [15:0] k,
		input int n);
		@(posedge mclk);
		ins <= '{op, d, r, pm[3:2], pm[1:0], b, k};
		vld <= 1'b1;
		#1;
		while (instr_ready !== 1'b1) begin @(posedge mclk); #1; end
		@(posedge mclk);
		vld <= 1'b0;
		lastc = 1;
		#1;
		while (instr_ready !== 1'b1 && lastc < 50) begin
			@(posedge mclk);
			#1 lastc++;
		end
		if (n > 0) chk(lastc, n);
		@(posedge mclk);
		#1;
	endtask : ex
	task automatic li(input logic [4:0] d, input logic [7:0] v);
		ex(cpx_pkg::OP_LOAD_IMM, d, 5'h0, 4'h0, 3'h0, {8'h00, v}, 1);
	endtask : li
	always @(posedge mclk) begin
		ticks <= ticks + 1;
		if (ticks == 5000) begin
			n_fail++;
			summarize();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{arst_n, vld, sw_wr, sw_rd, slow} = 5'h0;
		{ins, sw_addr, sw_wdata, n_fail, num_checks, m} = '0;
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		rc(cpx_pkg::FLAGS_OFS, cpx_pkg::FLAGS_RESET);
		rc(8'h10, 8'h00);
		li(5'h1A, 8'h40);
		li(5'h1C, 8'h50);
		li(5'h1E, 8'h11);
		li(5'h10, 8'h81);
		ex(cpx_pkg::OP_STORE_IND, 5'h0, 5'h10, 4'h1, 3'h0, 16'h0, 1);
		chk(i_mem.mem[8'h40], 8'h81);
		rc(8'h3A, 8'h41);
		ex(cpx_pkg::OP_LOAD_IND, 5'h11, 5'h0, 4'h2, 3'h0, 16'h0, 2);
		rc(8'h31, 8'h81);
		rc(8'h3A, 8'h40);
		ex(cpx_pkg::OP_LOAD_IND, 5'h12, 5'h0, 4'h1, 3'h0, 16'h0, 2);
		rc(8'h32, 8'h81);
		rc(8'h3A, 8'h41);
		ex(cpx_pkg::OP_STORE_DISP, 5'h0, 5'h10, 4'h4, 3'h0, 16'h3, 1);
		chk(i_mem.mem[8'h53], 8'h81);
		ex(cpx_pkg::OP_STORE_IND, 5'h0, 5'h10, 4'h6, 3'h0, 16'h0, 1);
		chk(i_mem.mem[8'h4F], 8'h81);
		rc(8'h3C, 8'h4F);
		ex(cpx_pkg::OP_LOAD_DISP, 5'h13, 5'h0, 4'h8, 3'h0, 16'h2, 2);
		rc(8'h33, 8'h49);
		rc(8'h3E, 8'h11);
		ex(cpx_pkg::OP_PGM_LOAD, 5'h14, 5'h0, 4'h9, 3'h0, 16'h0, 3);
		rc(8'h34, 8'hF7);
		ex(cpx_pkg::OP_PGM_LOAD, 5'h0, 5'h0, 4'h8, 3'h0, 16'h0, 3);
		rc(8'h20, 8'h09);
		ex(cpx_pkg::OP_STORE_DIRECT, 5'h0, 5'h10, 4'h0, 3'h0, 16'h60, 2);
		chk(i_mem.mem[8'h60], 8'h81);
		ex(cpx_pkg::OP_LOAD_DIRECT, 5'h15, 5'h0, 4'h0, 3'h0, 16'h60, 3);
		rc(8'h35, 8'h81);
		ex(cpx_pkg::OP_LOAD_DIRECT, 5'h16, 5'h0, 4'h0, 3'h0, 16'h1000, 4);
		rc(8'h36, 8'h5A);
		slow <= 1'b1;
		ex(cpx_pkg::OP_LOAD_DIRECT, 5'h16, 5'h0, 4'h0, 3'h0, 16'h1000, 0);
		chk(lastc > 4, 1'b1);
		slow <= 1'b0;
		ex(cpx_pkg::OP_IO_OUT, 5'h0, 5'h10, 4'h0, 3'h0, 16'h5, 1);
		chk(i_mem.io[5], 8'h81);
		ex(cpx_pkg::OP_IO_SET, 5'h0, 5'h0, 4'h0, 3'h1, 16'h5, 1);
		ex(cpx_pkg::OP_IO_CLR, 5'h0, 5'h0, 4'h0, 3'h7, 16'h5, 1);
		ex(cpx_pkg::OP_IO_IN, 5'h17, 5'h0, 4'h0, 3'h0, 16'h5, 1);
		rc(8'h37, 8'h03);
		ex(cpx_pkg::OP_PUSH, 5'h0, 5'h10, 4'h0, 3'h0, 16'h0, 1);
		chk(i_mem.mem[8'hFF], 8'h81);
		ex(cpx_pkg::OP_POP, 5'h18, 5'h0, 4'h0, 3'h0, 16'h0, 2);
		rc(8'h38, 8'h81);
		for (int i = 0; i < 8; i++) begin
			m = {m[6:0], 1'b1};
			ex(cpx_pkg::OP_FLAG_SET, 5'h0, 5'h0, 4'h0, i[2:0], 16'h0, 1);
			rc(cpx_pkg::FLAGS_OFS, m);
		end
		for (int i = 0; i < 8; i++) begin
			m = m << 1;
			ex(cpx_pkg::OP_FLAG_CLR, 5'h0, 5'h0, 4'h0, i[2:0], 16'h0, 1);
			rc(cpx_pkg::FLAGS_OFS, m);
		end
		ex(cpx_pkg::OP_FLAG_SET, 5'h0, 5'h0, 4'h0, 3'h3, 16'h0, 1);
		rpc();
		ob = pa;
		ex(cpx_pkg::OP_BR_VS, 5'h0, 5'h0, 4'h0, 3'h0, 16'h7D, 2);
		rpc();
		chk(pa, ob - 16'h2);
		ex(cpx_pkg::OP_BR_VC, 5'h0, 5'h0, 4'h0, 3'h0, 16'h7D, 1);
		ex(cpx_pkg::OP_BR_IE, 5'h0, 5'h0, 4'h0, 3'h0, 16'h5, 1);
		rpc();
		ob = pa;
		ex(cpx_pkg::OP_BR_ID, 5'h0, 5'h0, 4'h0, 3'h0, 16'h5, 2);
		rpc();
		chk(pa, ob + 16'h6);
		rc(cpx_pkg::FLAGS_OFS, 8'h08);
		ex(cpx_pkg::OP_FLAG_CLR, 5'h0, 5'h0, 4'h0, 3'h3, 16'h0, 1);
		ex(cpx_pkg::OP_SHL, 5'h10, 5'h0, 4'h0, 3'h0, 16'h0, 1);
		rc(8'h30, 8'h02);
		rc(cpx_pkg::FLAGS_OFS, 8'h09);
		ex(cpx_pkg::OP_ROL, 5'h10, 5'h0, 4'h0, 3'h0, 16'h0, 1);
		rc(8'h30, 8'h05);
		rc(cpx_pkg::FLAGS_OFS, 8'h00);
		ex(cpx_pkg::OP_SHR, 5'h10, 5'h0, 4'h0, 3'h0, 16'h0, 1);
		rc(cpx_pkg::FLAGS_OFS, 8'h09);
		ex(cpx_pkg::OP_ROR, 5'h10, 5'h0, 4'h0, 3'h0, 16'h0, 1);
		rc(8'h30, 8'h81);
		rc(cpx_pkg::FLAGS_OFS, 8'h0C);
		ex(cpx_pkg::OP_ASR, 5'h10, 5'h0, 4'h0, 3'h0, 16'h0, 1);
		rc(8'h30, 8'hC0);
		ex(cpx_pkg::OP_BIT_TO_T, 5'h0, 5'h10, 4'h0, 3'h7, 16'h0, 1);
		rc(cpx_pkg::FLAGS_OFS, 8'h45);
		chk(flags, 8'h45);
		ex(cpx_pkg::OP_T_TO_BIT, 5'h19, 5'h0, 4'h0, 3'h3, 16'h0, 1);
		rc(8'h39, 8'h08);
		ex(cpx_pkg::OP_COPY, 5'h1B, 5'h10, 4'h0, 3'h0, 16'h0, 1);
		rc(8'h3B, 8'hC0);
		ex(cpx_pkg::OP_COPY_PAIR, 5'h02, 5'h10, 4'h0, 3'h0, 16'h0, 1);
		rc(8'h22, 8'hC0);
		rc(8'h23, 8'h81);
		wr(cpx_pkg::CTRL_OFS, 8'h00);
		#1 chk(instr_ready, 1'b0);
		wr(cpx_pkg::CTRL_OFS, cpx_pkg::CTRL_RESET);
		summarize();
	end
endmodule : tb_cpu_transfer_bitop_branch_exec
